// ===== tpp_pkg.sv
package tpp_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 10;

    // Register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h111;
    localparam logic [IDX_W-1:0] IDX_CLKPER = 10'h112;
    localparam logic [IDX_W-1:0] IDX_PH_A = 10'h113;
    localparam logic [IDX_W-1:0] IDX_PH_B = 10'h114;

    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [6:0] RST_CLKPER = 7'h00;
    localparam logic [7:0] RST_PH = 8'h00;

    // modulator_control fields
    localparam int unsigned CTL_PHA_EN = 0;
    localparam int unsigned CTL_PHB_EN = 1;
    localparam int unsigned CTL_ROLE_LO = 2;
    localparam int unsigned CTL_ROLE_HI = 3;
    localparam int unsigned CTL_BLANK_A = 4;
    localparam int unsigned CTL_ASD_EN = 6;
    localparam int unsigned CTL_RESTART = 7;

    // clock_and_period_control fields
    localparam int unsigned CLK_STATUS = 7;
    localparam int unsigned CLK_PRESC_HI = 6;
    localparam int unsigned CLK_PRESC_LO = 5;
    localparam int unsigned CLK_PER_HI = 4;

    // Phase control fields
    localparam int unsigned PH_POL = 7;
    localparam int unsigned PH_C2 = 6;
    localparam int unsigned PH_C1 = 5;
    localparam int unsigned PH_OFS_HI = 4;

    // Sync role codes
    localparam logic [1:0] ROLE_SLAVE = 2'h2;
    localparam logic [1:0] ROLE_MASTER = 2'h3;

    localparam int unsigned NPH = 2;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'h0,
        RUN_WAIT = 2'h1,
        RUN_GO = 2'h3,
        RUN_SHUT = 2'h2
    } tpp_run_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } tpp_div_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [6:0] clkper;
        logic [NPH-1:0][7:0] ph;
        logic status;
        tpp_run_t run;
        logic [4:0] count;
        logic [NPH-1:0] active;
        logic [NPH-1:0] fresh;
        logic [NPH-1:0] pin;
        logic [NPH-1:0] oe;
        logic sync_out;
        logic casc_out;
        logic casc_oe;
        logic [1:0] sync_sd;
        logic [1:0] sync_c1;
        logic [1:0] sync_c2;
        logic [1:0] sync_casc;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } tpp_state_t;

endpackage : tpp_pkg

// ===== tpp_tick_div.sv
`timescale 1ns/100ps
`default_nettype none
module tpp_tick_div (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic clear,
    input wire logic [1:0] sel,
    // Modulation tick
    output logic tick
);

    tpp_pkg::tpp_div_t s_reg;
    tpp_pkg::tpp_div_t s_next;
    logic [2:0] mask;

    always_comb
    begin
        s_next = s_reg;
        mask = 3'((4'h1 << sel) - 4'h1);
        s_next.tick = ~clear & ((s_reg.cnt & mask) == mask);
        s_next.cnt = clear ? 3'h0 : 3'(s_reg.cnt + 3'h1);
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule : tpp_tick_div
`default_nettype wire

// ===== tpp_pwm.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module tpp_pwm (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tpp_pkg::ADDR_W-1:0] paddr,
    input wire logic [tpp_pkg::DATA_W-1:0] pwdata,
    output logic [tpp_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Feedback and shutdown inputs
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic shutdown_input_pin,
    // Cascade pin
    input wire logic cascade_pin_in,
    output logic cascade_pin_out,
    output logic cascade_pin_oe,
    // Phase outputs
    output logic phase_a_output,
    output logic phase_a_oe,
    output logic phase_b_output,
    output logic phase_b_oe
);

    tpp_pkg::tpp_state_t s_reg;
    tpp_pkg::tpp_state_t s_next;
    logic tick;

    function automatic logic reg_hit(
        input logic [tpp_pkg::ADDR_W-1:0] addr,
        input logic [tpp_pkg::IDX_W-1:0] idx
    );
        reg_hit = (addr[tpp_pkg::ADDR_W-1:2] == idx);
    endfunction : reg_hit

    tpp_tick_div u_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clear(s_reg.run != tpp_pkg::RUN_GO),
        .sel(s_reg.clkper[tpp_pkg::CLK_PRESC_HI:tpp_pkg::CLK_PRESC_LO]),
        .tick(tick)
    );

    always_comb
    begin
        logic setup;
        logic wr;
        logic any_hit;
        logic en;
        logic [1:0] role;
        logic slave;
        logic master;
        logic sd_cond;
        logic sw_clear;
        logic sw_set;
        logic restart;
        logic load;
        logic at_end;
        logic [4:0] per;
        logic trig;
        logic blank;
        setup = 1'b0;
        wr = 1'b0;
        any_hit = 1'b0;
        en = 1'b0;
        role = 2'h0;
        slave = 1'b0;
        master = 1'b0;
        sd_cond = 1'b0;
        sw_clear = 1'b0;
        sw_set = 1'b0;
        restart = 1'b0;
        load = 1'b0;
        at_end = 1'b0;
        per = 5'h0;
        trig = 1'b0;
        blank = 1'b0;
        s_next = s_reg;

        // Two-stage input synchronisers
        s_next.sync_sd = {s_reg.sync_sd[0], shutdown_input_pin};
        s_next.sync_c1 = {s_reg.sync_c1[0], comparator_one_output};
        s_next.sync_c2 = {s_reg.sync_c2[0], comparator_two_output};
        s_next.sync_casc = {s_reg.sync_casc[0], cascade_pin_in};

        // Bus: answer in the first access cycle
        setup = psel & ~penable;
        any_hit = reg_hit(paddr, tpp_pkg::IDX_CTRL)
                | reg_hit(paddr, tpp_pkg::IDX_CLKPER)
                | reg_hit(paddr, tpp_pkg::IDX_PH_A)
                | reg_hit(paddr, tpp_pkg::IDX_PH_B);
        s_next.pready = setup;
        s_next.pslverr = setup & ~any_hit;
        if (setup)
        begin
            s_next.prdata = '0;
            if (reg_hit(paddr, tpp_pkg::IDX_CTRL))
                s_next.prdata[7:0] = s_reg.ctrl;
            if (reg_hit(paddr, tpp_pkg::IDX_CLKPER))
                s_next.prdata[7:0] = {s_reg.status, s_reg.clkper};
            if (reg_hit(paddr, tpp_pkg::IDX_PH_A))
                s_next.prdata[7:0] = s_reg.ph[0];
            if (reg_hit(paddr, tpp_pkg::IDX_PH_B))
                s_next.prdata[7:0] = s_reg.ph[1];
        end
        wr = psel & penable & pwrite & s_reg.pready;
        if (wr & reg_hit(paddr, tpp_pkg::IDX_CTRL))
            s_next.ctrl = pwdata[7:0];
        if (wr & reg_hit(paddr, tpp_pkg::IDX_CLKPER))
            s_next.clkper = pwdata[6:0];
        if (wr & reg_hit(paddr, tpp_pkg::IDX_PH_A))
            s_next.ph[0] = pwdata[7:0];
        if (wr & reg_hit(paddr, tpp_pkg::IDX_PH_B))
            s_next.ph[1] = pwdata[7:0];

        en = s_reg.ctrl[tpp_pkg::CTL_PHA_EN] | s_reg.ctrl[tpp_pkg::CTL_PHB_EN];
        role = s_reg.ctrl[tpp_pkg::CTL_ROLE_HI:tpp_pkg::CTL_ROLE_LO];
        slave = (role == tpp_pkg::ROLE_SLAVE);
        master = (role == tpp_pkg::ROLE_MASTER);
        restart = s_reg.ctrl[tpp_pkg::CTL_RESTART];
        per = s_reg.clkper[tpp_pkg::CLK_PER_HI:0];

        sd_cond = s_reg.ctrl[tpp_pkg::CTL_ASD_EN] & en & ~s_reg.sync_sd[1];
        sw_clear = wr & reg_hit(paddr, tpp_pkg::IDX_CLKPER)
                 & ~pwdata[tpp_pkg::CLK_STATUS];
        sw_set = wr & reg_hit(paddr, tpp_pkg::IDX_CLKPER)
               & pwdata[tpp_pkg::CLK_STATUS] & ~restart;
        if (sd_cond | sw_set)
            s_next.status = 1'b1;
        else if (s_reg.status & (restart | sw_clear))
            s_next.status = 1'b0;

        s_next.sync_out = 1'b0;
        case (s_reg.run)
            tpp_pkg::RUN_IDLE:
            begin
                s_next.count = 5'h0;
                if (en)
                    s_next.run = slave ? tpp_pkg::RUN_WAIT : tpp_pkg::RUN_GO;
            end
            tpp_pkg::RUN_WAIT:
            begin
                s_next.count = 5'h0;
                if (s_reg.sync_casc[1])
                begin
                    s_next.run = tpp_pkg::RUN_GO;
                    load = 1'b1;
                end
            end
            tpp_pkg::RUN_GO:
            begin
                if (tick)
                begin
                    load = 1'b1;
                    at_end = (s_reg.count == per);
                    if ((slave & s_reg.sync_casc[1]) | at_end)
                        s_next.count = 5'h0;
                    else
                        s_next.count = 5'(s_reg.count + 5'h1);
                    s_next.sync_out = at_end;
                end
                else
                begin
                    s_next.sync_out = s_reg.sync_out;
                end
            end
            tpp_pkg::RUN_SHUT:
            begin
                s_next.count = 5'h0;
                if (!s_next.status)
                    s_next.run = slave ? tpp_pkg::RUN_WAIT : tpp_pkg::RUN_GO;
            end
            default:
            begin
                s_next.run = tpp_pkg::RUN_IDLE;
                s_next.count = 5'h0;
            end
        endcase
        if (!en)
        begin
            s_next.run = tpp_pkg::RUN_IDLE;
            s_next.count = 5'h0;
            s_next.sync_out = 1'b0;
            load = 1'b0;
        end
        else if (s_next.status)
        begin
            s_next.run = tpp_pkg::RUN_SHUT;
            s_next.count = 5'h0;
            s_next.sync_out = 1'b0;
            load = 1'b0;
        end

        for (int i = 0; i < tpp_pkg::NPH; i++)
        begin
            trig = (s_reg.ph[i][tpp_pkg::PH_C1] & s_reg.sync_c1[1])
                 | (s_reg.ph[i][tpp_pkg::PH_C2] & s_reg.sync_c2[1]);
            blank = s_reg.ctrl[tpp_pkg::CTL_BLANK_A + i];
            if ((s_next.run != tpp_pkg::RUN_GO) | ~s_reg.ctrl[i])
            begin
                s_next.active[i] = 1'b0;
                s_next.fresh[i] = 1'b0;
            end
            else if (load
                     & (s_next.count == s_reg.ph[i][tpp_pkg::PH_OFS_HI:0]))
            begin
                s_next.active[i] = 1'b1;
                s_next.fresh[i] = 1'b1;
            end
            else
            begin
                s_next.fresh[i] = 1'b0;
                if (s_reg.active[i] & trig & ~(blank & s_reg.fresh[i]))
                    s_next.active[i] = 1'b0;
            end
            s_next.pin[i] = s_next.active[i] ^ s_reg.ph[i][tpp_pkg::PH_POL];
            s_next.oe[i] = s_reg.ctrl[i];
        end

        s_next.casc_oe = master;
        s_next.casc_out = master & s_next.sync_out;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
            s_reg.ctrl <= tpp_pkg::RST_CTRL;
            s_reg.clkper <= tpp_pkg::RST_CLKPER;
            s_reg.ph <= {tpp_pkg::RST_PH, tpp_pkg::RST_PH};
            s_reg.run <= tpp_pkg::RUN_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign cascade_pin_out = s_reg.casc_out;
    assign cascade_pin_oe = s_reg.casc_oe;
    assign phase_a_output = s_reg.pin[0];
    assign phase_a_oe = s_reg.oe[0];
    assign phase_b_output = s_reg.pin[1];
    assign phase_b_oe = s_reg.oe[1];

endmodule : tpp_pwm
`default_nettype wire

// ===== tpp_pwm_properties.sv
`timescale 1ns/100ps
`default_nettype none
module tpp_pwm_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tpp_pkg::ADDR_W-1:0] paddr,
    input wire logic [tpp_pkg::DATA_W-1:0] pwdata,
    input wire logic [tpp_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic shutdown_input_pin,
    input wire logic cascade_pin_out,
    input wire logic cascade_pin_oe,
    input wire logic phase_a_output,
    input wire logic phase_a_oe
);
    logic [7:0] ctl_reg;
    logic pol_reg;
    logic [1:0] psc_reg;
    logic [1:0] age_reg;
    logic wr;
    logic [9:0] ix;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    assign wr = psel && penable && pready && pwrite;
    assign ix = paddr[11:2];
    // Shadow of written settings, age since last write
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctl_reg <= 8'h00;
            pol_reg <= 1'b0;
            psc_reg <= 2'h0;
            age_reg <= 2'h0;
        end
        else
        begin
            if (wr && ix == tpp_pkg::IDX_CTRL)
                ctl_reg <= pwdata[7:0];
            if (wr && ix == tpp_pkg::IDX_PH_A)
                pol_reg <= pwdata[7];
            if (wr && ix == tpp_pkg::IDX_CLKPER)
                psc_reg <= pwdata[6:5];
            if (wr)
                age_reg <= 2'h0;
            else if (age_reg != 2'h3)
                age_reg <= age_reg + 2'h1;
        end
    end
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (pready |-> pslverr == (ix <
        tpp_pkg::IDX_CTRL || ix > tpp_pkg::IDX_PH_B))
        else $error("pslverr wrong for address");
    AST_CASC_OE: assert property (age_reg == 2'h3 |->
        cascade_pin_oe == (ctl_reg[3:2] == 2'h3))
        else $error("cascade enable does not follow role");
    AST_SYNC_ONE: assert property (cascade_pin_out && psc_reg == 2'h0
        && age_reg == 2'h3 |=> !cascade_pin_out)
        else $error("sync pulse longer than one tick");
    AST_IDLE: assert property (age_reg == 2'h3 &&
        ctl_reg[1:0] == 2'h0 |-> !cascade_pin_out)
        else $error("sync pulse while both phases off");
    AST_OE_A: assert property (age_reg == 2'h3 |->
        phase_a_oe == ctl_reg[0])
        else $error("phase a enable does not follow control");
    AST_POL_OFF: assert property (age_reg == 2'h3 && !ctl_reg[0] |->
        phase_a_output == pol_reg)
        else $error("disabled phase a not at inactive level");
    AST_SHUT: assert property ((!shutdown_input_pin && ctl_reg[6] &&
        age_reg == 2'h3) [*6] |-> phase_a_output == pol_reg &&
        !cascade_pin_out)
        else $error("shutdown did not stop outputs");
    cover property (cascade_pin_out && psc_reg == 2'h3);
    cover property (pready && pslverr);
    cover property (!shutdown_input_pin && ctl_reg[6]);
endmodule : tpp_pwm_checker
bind tpp_pwm tpp_pwm_checker u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_input_pin(shutdown_input_pin),
    .cascade_pin_out(cascade_pin_out), .cascade_pin_oe(cascade_pin_oe),
    .phase_a_output(phase_a_output), .phase_a_oe(phase_a_oe));
`default_nettype wire

// ===== tpp_sync_peer.sv
`timescale 1ns/100ps
`default_nettype none
module tpp_sync_peer #(
    parameter int PER = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    // Cascade line
    output logic sync_out,
    output logic sync_oe
);
    logic [4:0] cnt_reg;
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !run)
            cnt_reg <= 5'h00;
        else
            cnt_reg <= (cnt_reg == 5'(PER)) ? 5'h00 : cnt_reg + 5'h01;
    end
    assign sync_out = run && (cnt_reg == 5'(PER));
    assign sync_oe = run;
endmodule : tpp_sync_peer
`default_nettype wire

// ===== two_phase_pwm_sync_shutdown_test.sv
`timescale 1ns/100ps
`default_nettype none
module two_phase_pwm_sync_shutdown_test;
    localparam logic [11:0] A_CT = 12'h444;
    localparam logic [11:0] A_CK = 12'h448;
    localparam logic [11:0] A_PA = 12'h44c;
    localparam logic [11:0] A_PB = 12'h450;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, se, cp_out, cp_oe, pa, pa_oe, pb, pb_oe;
    logic c1 = 1'b0;
    logic c2 = 1'b0;
    logic sd = 1'b1;
    logic m_run = 1'b0;
    logic m_out, m_oe;
    wire logic casc;
    int err_count = 0;
    int checks_done = 0;
    int t0, g;
    // Pull-down when nobody drives the line
    assign casc = cp_oe ? cp_out : (m_oe ? m_out : 1'b0);
    always #20 mclk = ~mclk;
    tpp_pwm DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_one_output(c1),
        .comparator_two_output(c2), .shutdown_input_pin(sd),
        .cascade_pin_in(casc), .cascade_pin_out(cp_out),
        .cascade_pin_oe(cp_oe), .phase_a_output(pa), .phase_a_oe(pa_oe),
        .phase_b_output(pb), .phase_b_oe(pb_oe));
    tpp_sync_peer #(.PER(3)) u_peer (.mclk(mclk), .sys_rst(sys_rst),
        .run(m_run), .sync_out(m_out), .sync_oe(m_oe));
    task chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        chk("prdata", q, {24'h0, e});
    endtask : rd
    task gap(output int n);
        @(posedge cp_out);
        t0 = $time;
        @(posedge cp_out);
        n = ($time - t0) / 40;
    endtask : gap
    task hi(input int n, output int k);
        k = 0;
        repeat (n) @(posedge mclk) k += (cp_out === 1'b1);
    endtask : hi
    // Cycles with phase b low
    task lo_b(input int n, output int k);
        k = 0;
        repeat (n) @(posedge mclk) k += (pb === 1'b0);
    endtask : lo_b
    task finish_test;
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial
    begin
        #400000;
        err_count++;
        finish_test;
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            rd(12'h444 + 12'(4 * i), 8'h00);
        rd(12'h454, 8'h00);
        chk("pslverr", se, 1'b1);
        wr(A_PA, 8'h9f);
        rd(A_PA, 8'h9f);
        $display("Test registers done");
        wr(A_PA, 8'h00);
        wr(A_CT, 8'h0d);
        for (int p = 0; p < 4; p++)
        begin
            wr(A_CK, 8'(32 * p + 3));
            gap(g);
            gap(g);
            chk("period", g, 32'(4 << p));
        end
        wr(A_CK, 8'h1f);
        gap(g);
        gap(g);
        chk("period", g, 32);
        wr(A_CK, 8'h0f);
        for (int i = 0; i < 2; i++)
        begin
            wr(A_PA, 8'(32 << i) | 8'h06);
            {c2, c1} <= 2'(1 << i);
            repeat (6) @(posedge mclk);
            chk("phase_a", pa, 1'b0);
            @(posedge cp_out);
            {c2, c1} <= 2'b00;
            t0 = $time;
            @(posedge pa);
            chk("offset", ($time - t0) / 40, 6);
            {c2, c1} <= 2'(2 >> i);
            repeat (6) @(posedge mclk);
            chk("phase_a", pa, 1'b1);
            {c2, c1} <= 2'b00;
        end
        $display("Test master done");
        wr(A_PA, 8'h00);
        sd <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(A_CK, 8'h0f);
        chk("phase_a", pa, 1'b1);
        wr(A_CT, 8'h4d);
        repeat (6) @(posedge mclk);
        chk("phase_a", pa, 1'b0);
        rd(A_CK, 8'h8f);
        wr(A_CK, 8'h0f);
        rd(A_CK, 8'h8f);
        sd <= 1'b1;
        hi(40, g);
        chk("pulses", g, 0);
        rd(A_CK, 8'h8f);
        wr(A_CK, 8'h0f);
        rd(A_CK, 8'h0f);
        gap(g);
        chk("period", g, 16);
        wr(A_CK, 8'h8f);
        rd(A_CK, 8'h8f);
        hi(40, g);
        chk("pulses", g, 0);
        wr(A_CK, 8'h0f);
        wr(A_CT, 8'hcd);
        sd <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(A_CK, 8'h8f);
        sd <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(A_CK, 8'h0f);
        gap(g);
        chk("period", g, 16);
        $display("Test shutdown done");
        wr(A_CT, 8'h00);
        hi(40, g);
        chk("pulses", g, 0);
        wr(A_PA, 8'h22);
        wr(A_CT, 8'h09);
        c1 <= 1'b1;
        repeat (6) @(posedge mclk);
        c1 <= 1'b0;
        repeat (40) @(posedge mclk);
        chk("phase_a", pa, 1'b0);
        m_run <= 1'b1;
        repeat (30) @(posedge mclk);
        chk("phase_a", pa, 1'b1);
        $display("Test slave done");
        m_run <= 1'b0;
        wr(A_PB, 8'ha4);
        rd(A_PB, 8'ha4);
        wr(A_CT, 8'h22);
        c1 <= 1'b1;
        repeat (40) @(posedge mclk);
        chk("phase_b_oe", pb_oe, 1'b1);
        chk("cascade_oe", cp_oe, 1'b0);
        lo_b(32, g);
        chk("blanked", g, 4);
        wr(A_CT, 8'h02);
        repeat (40) @(posedge mclk);
        lo_b(32, g);
        chk("unblanked", g, 2);
        c1 <= 1'b0;
        wr(A_CT, 8'h00);
        repeat (3) @(posedge mclk);
        chk("phase_b", pb, 1'b1);
        chk("phase_b_oe", pb_oe, 1'b0);
        $display("Test phase b done");
        finish_test;
    end
endmodule : two_phase_pwm_sync_shutdown_test
`default_nettype wire
